// ===== rtl/usb_status_regs.svh
// Constants for the endpoint and status report logic
`ifndef USB_STATUS_REGS_SVH
`define USB_STATUS_REGS_SVH

// Interface descriptor
`define IF_DESC_LEN      8'h09
`define IF_DESC_TYPE     8'h04
`define IF_NUMBER        8'h00
`define IF_ALT_SETTING   8'h00
`define IF_NUM_EP        8'h05
`define IF_CLASS         8'hFF
`define IF_SUBCLASS      8'h00
`define IF_PROTOCOL      8'hFF
`define IF_STRING        8'h00

// Endpoint descriptors
`define EP_DESC_LEN      8'h07
`define EP_DESC_TYPE     8'h05
`define EP_ATTR_BULK     8'h02
`define EP_ATTR_INTR     8'h03
`define EP_PRN_IN_ADDR   8'h81
`define EP_PRN_OUT_ADDR  8'h02
`define EP_SER_IN_ADDR   8'h83
`define EP_SER_OUT_ADDR  8'h04
`define EP_STAT_ADDR     8'h87
`define EP_MPS_32        16'h0020
`define EP_MPS_64        16'h0040
`define EP_MPS_4         16'h0004
`define EP_IVL_FF        8'hFF
`define EP_IVL_01        8'h01
`define EP0_MAX_PACKET   8'h08
`define DESC_TOTAL_LEN   6'h2C

// Vendor requests
`define VREQ_RD_TYPE     8'hC0
`define VREQ_WR_TYPE     8'h40
`define VREQ_RD          8'h0D
`define VREQ_WR          8'h0E
`define VSEL_CTRL        8'h00
`define VSEL_PRINTER     8'h01
`define VSEL_SERIAL      8'h02

// Status byte four bit positions
`define B4_PRN_IN_FULL   0
`define B4_PRN_IN_EMPTY  1
`define B4_PRN_OUT_FULL  2
`define B4_PRN_OUT_EMPTY 3
`define B4_SER_OUT_EMPTY 4
`define B4_SER_IN_DATA   5
`define STAT_RSVD_BYTE   8'h00
`define STAT_BYTES       3'h4

// Report timing
`define REPORT_PERIOD_US 1000
`define SYS_CLK_MHZ      20
`define REPORT_CYCLES    (`REPORT_PERIOD_US * `SYS_CLK_MHZ)

// Local register port
`define REG_CTRL_OFS     8'h00
`define REG_REPORT_OFS   8'h04
`define REG_STATE_OFS    8'h08
`define REG_CTRL_RST     1'b1
`define CTRL_EN_BIT      0
`define STATE_READY_BIT  0
`define STATE_BUSY_BIT   1

`endif

// ===== rtl/usb_status_pkg.sv
// Types for the endpoint and status report logic
package usb_status_pkg;

  typedef struct packed {
    logic [7:0] fifo;
    logic [7:0] dsr;
    logic [7:0] rsvd;
    logic [7:0] serial_irq_ident_reg;
  } report_t;

  typedef struct packed {
    logic serial_in_fifo_has_data_flag;
    logic serial_out_fifo_empty_flag;
    logic printer_out_fifo_empty_flag;
    logic printer_out_fifo_full_flag;
    logic printer_in_fifo_empty_flag;
    logic printer_in_fifo_full_flag;
  } fifo_flags_t;

  typedef struct packed {
    logic [15:0] length;
    logic [15:0] index;
    logic [15:0] value;
    logic [7:0]  request;
    logic [7:0]  req_type;
  } setup_t;

  typedef struct packed {
    logic [7:0]  sel;
    logic [15:0] ofs;
    logic [7:0]  wdata;
  } app_req_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  attr;
    logic [15:0] mps;
    logic [7:0]  interval;
  } ep_desc_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } send_state_t;

endpackage : usb_status_pkg

// ===== rtl/status_sampler.sv
// Status report snapshot taken at each report tick
`timescale 1ns/1ps
`include "usb_status_regs.svh"

module status_sampler
  import usb_status_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic [7:0]  serial_irq_ident_reg,
  input  wire logic [7:0]  dsr,
  input  wire fifo_flags_t flags,
  output report_t          report_r
);

  report_t report_nxt;

  always_comb begin
    report_nxt                             = report_r;
    report_nxt.serial_irq_ident_reg                         = serial_irq_ident_reg;
    report_nxt.rsvd                        = `STAT_RSVD_BYTE;
    report_nxt.dsr                         = dsr;
    report_nxt.fifo                        = 8'h00;
    report_nxt.fifo[`B4_PRN_IN_FULL]   = flags.printer_in_fifo_full_flag;
    report_nxt.fifo[`B4_PRN_IN_EMPTY]  = flags.printer_in_fifo_empty_flag;
    report_nxt.fifo[`B4_PRN_OUT_FULL]  = flags.printer_out_fifo_full_flag;
    report_nxt.fifo[`B4_PRN_OUT_EMPTY] = flags.printer_out_fifo_empty_flag;
    report_nxt.fifo[`B4_SER_OUT_EMPTY] = flags.serial_out_fifo_empty_flag;
    report_nxt.fifo[`B4_SER_IN_DATA]   = flags.serial_in_fifo_has_data_flag;
  end

  // Fresh capture at every tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      report_r <= '0;
    end else if (tick) begin
      report_r <= report_nxt;
    end
  end

  property p_snap_iir;
    @(posedge clk) disable iff (rst) tick |=> report_r.serial_irq_ident_reg == $past(serial_irq_ident_reg);
  endproperty
  a_snap_iir: assert property (p_snap_iir) else $error("iir not captured");

  property p_prn_in;
    @(posedge clk) disable iff (rst)
      tick |=> report_r.fifo[1:0] == $past({flags.printer_in_fifo_empty_flag, flags.printer_in_fifo_full_flag});
  endproperty
  a_prn_in: assert property (p_prn_in) else $error("printer in flags wrong");

  property p_prn_out;
    @(posedge clk) disable iff (rst)
      tick |=> report_r.fifo[3:2] == $past({flags.printer_out_fifo_empty_flag, flags.printer_out_fifo_full_flag});
  endproperty
  a_prn_out: assert property (p_prn_out) else $error("printer out flags wrong");

  property p_ser_flags;
    @(posedge clk) disable iff (rst)
      tick |=> report_r.fifo[5:4] == $past({flags.serial_in_fifo_has_data_flag, flags.serial_out_fifo_empty_flag});
  endproperty
  a_ser_flags: assert property (p_ser_flags) else $error("serial flags wrong");

endmodule : status_sampler

// ===== rtl/usb_endpoint_status_reporter.sv
// Interface and endpoint descriptors, vendor request decode and status reports
`timescale 1ns/1ps
`include "usb_status_regs.svh"

// How it works
// - Nine byte vendor interface descriptor, five endpoints
// - Five endpoints besides control endpoint zero
// - Printer bulk in: 81, 32 bytes, FF
// - Printer bulk out: 02, 32 bytes, FF
// - Serial bulk in: 83, 64 bytes, 01
// - Serial bulk out: 04, 32 bytes, FF
// - Status interrupt in: 87, 4 bytes, 1ms
// - Fresh four byte report every millisecond
// - Byte one serial ident, byte two zero
// - Byte three printer device status
// - Byte four flags low, top bits zero
// - Bits 0,1 printer in full, empty
// - Bits 2,3 printer out full, empty
// - Bit 4 serial out FIFO empty
// - Bit 5 serial in FIFO holds data
// - Host configures ports through vendor requests
// - Control endpoint zero packet size eight
// - Request 0D reads, 0E writes, index offset
// - Value high byte selects target, low data
module usb_endpoint_status_reporter
  import usb_status_pkg::*;
#(
  parameter int REPORT_CYCLES = `REPORT_CYCLES
)
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  SERIAL_IRQ_IDENT_REG,
  input  wire logic [7:0]  PRINTER_STATUS_REG,
  input  wire logic        PRINTER_IN_FIFO_FULL_FLAG,
  input  wire logic        PRINTER_IN_FIFO_EMPTY_FLAG,
  input  wire logic        PRINTER_OUT_FIFO_FULL_FLAG,
  input  wire logic        PRINTER_OUT_FIFO_EMPTY_FLAG,
  input  wire logic        SERIAL_OUT_FIFO_EMPTY_FLAG,
  input  wire logic        SERIAL_IN_FIFO_HAS_DATA_FLAG,
  input  wire logic        STAT_IN_REQ,
  output logic [7:0]       STAT_DATA,
  output logic             STAT_VLD,
  output logic             STAT_LAST,
  output logic             STAT_NAK,
  input  wire logic        DESC_RD,
  input  wire logic [5:0]  DESC_ADDR,
  output logic [7:0]       DESC_DATA,
  output logic [7:0]       EP0_MAX_PKT,
  input  wire logic        SETUP_VLD,
  input  wire setup_t      SETUP,
  output logic             CTL_ACK,
  output logic             CTL_STALL,
  output logic [7:0]       CTL_RDATA,
  output logic             CTL_RDATA_VLD,
  output logic             APP_RD,
  output logic             APP_WR,
  output app_req_t         APP_REQ,
  input  wire logic [7:0]  APP_RDATA,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA
);

  localparam int TMR_W = $clog2(REPORT_CYCLES);
  localparam int N_EP  = 5;

  localparam ep_desc_t EP_TAB [N_EP] = '{
    '{`EP_PRN_IN_ADDR,  `EP_ATTR_BULK, `EP_MPS_32, `EP_IVL_FF},
    '{`EP_PRN_OUT_ADDR, `EP_ATTR_BULK, `EP_MPS_32, `EP_IVL_FF},
    '{`EP_SER_IN_ADDR,  `EP_ATTR_BULK, `EP_MPS_64, `EP_IVL_01},
    '{`EP_SER_OUT_ADDR, `EP_ATTR_BULK, `EP_MPS_32, `EP_IVL_FF},
    '{`EP_STAT_ADDR,    `EP_ATTR_INTR, `EP_MPS_4,  `EP_IVL_01}
  };

  logic [TMR_W-1:0] tmr_r;
  logic             tick;
  logic             ctrl_en_r;
  logic             ready_r;
  logic             start;
  send_state_t      state_r;
  logic [2:0]       cnt_r;
  logic [31:0]      shift_r;
  report_t          report;
  fifo_flags_t      flags;
  logic [7:0]       desc_nxt;
  logic [5:0]       rel;
  logic [2:0]       ep_i;
  logic [2:0]       ep_b;
  logic             vrd;
  logic             vwr;
  logic             sel_ok;
  logic             rd_pend_r;

  // Report period timer
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      tmr_r <= '0;
    end else if (tick) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  assign tick = (tmr_r == TMR_W'(REPORT_CYCLES - 1));

  assign flags = '{
    serial_in_fifo_has_data_flag: SERIAL_IN_FIFO_HAS_DATA_FLAG,
    serial_out_fifo_empty_flag:   SERIAL_OUT_FIFO_EMPTY_FLAG,
    printer_out_fifo_empty_flag:  PRINTER_OUT_FIFO_EMPTY_FLAG,
    printer_out_fifo_full_flag:   PRINTER_OUT_FIFO_FULL_FLAG,
    printer_in_fifo_empty_flag:   PRINTER_IN_FIFO_EMPTY_FLAG,
    printer_in_fifo_full_flag:    PRINTER_IN_FIFO_FULL_FLAG
  };

  status_sampler u_sampler (
    .clk      (SYS_CLK),
    .rst      (RESET),
    .tick     (tick),
    .serial_irq_ident_reg      (SERIAL_IRQ_IDENT_REG),
    .dsr      (PRINTER_STATUS_REG),
    .flags    (flags),
    .report_r (report)
  );

  // Report ready flag, new report wins over a start
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ready_r <= 1'b0;
    end else if (tick && ctrl_en_r) begin
      ready_r <= 1'b1;
    end else if (start) begin
      ready_r <= 1'b0;
    end
  end

  assign start    = STAT_IN_REQ && ready_r && (state_r == ST_IDLE);
  assign STAT_NAK = STAT_IN_REQ && !start;

  // Status endpoint sender
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_r <= ST_IDLE;
      cnt_r   <= 3'h0;
      shift_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_SEND;
            cnt_r   <= 3'h0;
            shift_r <= report;
          end
        end
        ST_SEND: begin
          shift_r <= {8'h00, shift_r[31:8]};
          cnt_r   <= cnt_r + 3'h1;
          if (cnt_r == `STAT_BYTES - 3'h1) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign STAT_VLD  = (state_r == ST_SEND);
  assign STAT_LAST = STAT_VLD && (cnt_r == `STAT_BYTES - 3'h1);
  assign STAT_DATA = shift_r[7:0];

  // Interface and endpoint descriptor bytes
  always_comb begin
    desc_nxt = 8'h00;
    rel      = 6'(DESC_ADDR - 6'(`IF_DESC_LEN));
    ep_i     = 3'(rel / 6'(`EP_DESC_LEN));
    ep_b     = 3'(rel % 6'(`EP_DESC_LEN));
    if (DESC_ADDR < 6'(`IF_DESC_LEN)) begin
      case (DESC_ADDR)
        6'h00:   desc_nxt = `IF_DESC_LEN;
        6'h01:   desc_nxt = `IF_DESC_TYPE;
        6'h02:   desc_nxt = `IF_NUMBER;
        6'h03:   desc_nxt = `IF_ALT_SETTING;
        6'h04:   desc_nxt = `IF_NUM_EP;
        6'h05:   desc_nxt = `IF_CLASS;
        6'h06:   desc_nxt = `IF_SUBCLASS;
        6'h07:   desc_nxt = `IF_PROTOCOL;
        default: desc_nxt = `IF_STRING;
      endcase
    end else if (DESC_ADDR < `DESC_TOTAL_LEN) begin
      case (ep_b)
        3'h0:    desc_nxt = `EP_DESC_LEN;
        3'h1:    desc_nxt = `EP_DESC_TYPE;
        3'h2:    desc_nxt = EP_TAB[ep_i].addr;
        3'h3:    desc_nxt = EP_TAB[ep_i].attr;
        3'h4:    desc_nxt = EP_TAB[ep_i].mps[7:0];
        3'h5:    desc_nxt = EP_TAB[ep_i].mps[15:8];
        default: desc_nxt = EP_TAB[ep_i].interval;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      DESC_DATA <= 8'h00;
    end else if (DESC_RD) begin
      DESC_DATA <= desc_nxt;
    end
  end

  assign EP0_MAX_PKT = `EP0_MAX_PACKET;

  // Vendor request decode
  assign sel_ok = (SETUP.value[15:8] == `VSEL_CTRL) || (SETUP.value[15:8] == `VSEL_PRINTER)
               || (SETUP.value[15:8] == `VSEL_SERIAL);
  assign vrd    = SETUP_VLD && sel_ok && (SETUP.req_type == `VREQ_RD_TYPE) && (SETUP.request == `VREQ_RD);
  assign vwr    = SETUP_VLD && sel_ok && (SETUP.req_type == `VREQ_WR_TYPE) && (SETUP.request == `VREQ_WR);

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      APP_RD    <= 1'b0;
      APP_WR    <= 1'b0;
      CTL_ACK   <= 1'b0;
      CTL_STALL <= 1'b0;
      APP_REQ   <= '0;
    end else begin
      APP_RD    <= vrd;
      APP_WR    <= vwr;
      CTL_ACK   <= vwr;
      CTL_STALL <= SETUP_VLD && !vrd && !vwr;
      if (vrd || vwr) begin
        APP_REQ <= '{sel: SETUP.value[15:8], ofs: SETUP.index, wdata: SETUP.value[7:0]};
      end
    end
  end

  // Read data from the port cores
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rd_pend_r     <= 1'b0;
      CTL_RDATA     <= 8'h00;
      CTL_RDATA_VLD <= 1'b0;
    end else begin
      rd_pend_r     <= APP_RD;
      CTL_RDATA_VLD <= rd_pend_r;
      if (rd_pend_r) begin
        CTL_RDATA <= APP_RDATA;
      end
    end
  end

  // Local register port
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_en_r <= `REG_CTRL_RST;
    end else if (REG_WR && (REG_ADDR == `REG_CTRL_OFS)) begin
      ctrl_en_r <= REG_WDATA[`CTRL_EN_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `REG_CTRL_OFS:   REG_RDATA <= {31'h0000_0000, ctrl_en_r};
        `REG_REPORT_OFS: REG_RDATA <= report;
        `REG_STATE_OFS:  REG_RDATA <= {30'h0000_0000, STAT_VLD, ready_r};
        default:         REG_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  property p_four_bytes;
    start |=> STAT_VLD [*4] ##1 !STAT_VLD;
  endproperty
  a_four_bytes: assert property (p_four_bytes) else $error("report not four bytes");

  property p_ready_on_tick;
    tick && ctrl_en_r |=> ready_r;
  endproperty
  a_ready_on_tick: assert property (p_ready_on_tick) else $error("report not ready after tick");

  property p_byte_order;
    start |=> STAT_DATA == $past(report.serial_irq_ident_reg) ##1 STAT_DATA == `STAT_RSVD_BYTE ##1 STAT_DATA == $past(report.dsr, 3);
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("report byte order wrong");

  property p_byte_four;
    start |=> ##3 STAT_LAST && STAT_DATA[7:6] == 2'b00;
  endproperty
  a_byte_four: assert property (p_byte_four) else $error("byte four reserved bits set");

  property p_if_ep_count;
    DESC_RD && DESC_ADDR == 6'h04 |=> DESC_DATA == `IF_NUM_EP;
  endproperty
  a_if_ep_count: assert property (p_if_ep_count) else $error("endpoint count wrong");

  property p_stat_ep_addr;
    DESC_RD && DESC_ADDR == 6'h27 |=> DESC_DATA == `EP_STAT_ADDR;
  endproperty
  a_stat_ep_addr: assert property (p_stat_ep_addr) else $error("status endpoint address wrong");

  property p_vread;
    vrd |=> APP_RD && !APP_WR ##2 CTL_RDATA_VLD && CTL_RDATA == $past(APP_RDATA);
  endproperty
  a_vread: assert property (p_vread) else $error("vendor read not served");

  property p_vwrite;
    vwr |=> APP_WR && APP_REQ.wdata == $past(SETUP.value[7:0]) && APP_REQ.sel == $past(SETUP.value[15:8]);
  endproperty
  a_vwrite: assert property (p_vwrite) else $error("vendor write fields wrong");

  property p_stall;
    SETUP_VLD && !sel_ok |=> CTL_STALL && !APP_RD && !APP_WR;
  endproperty
  a_stall: assert property (p_stall) else $error("bad request not stalled");

  property p_ep0;
    EP0_MAX_PKT == `EP0_MAX_PACKET;
  endproperty
  a_ep0: assert property (p_ep0) else $error("ep0 packet size wrong");

  c_send: cover property (start ##4 STAT_LAST);
  c_nak: cover property (STAT_IN_REQ && !ready_r);
  c_read: cover property (vrd ##3 CTL_RDATA_VLD);
  c_write: cover property (vwr);

endmodule : usb_endpoint_status_reporter

// ===== tb/app_core_model.sv
// Application register core that answers vendor reads and writes
`timescale 1ns/1ps

module app_core_model
  import usb_status_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rd,
  input  wire logic     wr,
  input  wire app_req_t req,
  output logic [7:0]    rdata
);
  logic [7:0] mem [0:63];

  initial begin
    rdata = 8'h00;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'h00;
    end
  end

  // Store by target and offset, answer the cycle after a read
  always @(posedge clk) begin
    if (wr) begin
      mem[{req.sel[1:0], req.ofs[3:0]}] <= req.wdata;
    end
    // Released data line toggles instead of holding the last value
    rdata <= rd ? mem[{req.sel[1:0], req.ofs[3:0]}] : ~rdata;
  end
endmodule : app_core_model

// ===== tb/testbench.sv
// Self-checking bench for the endpoint and status report logic
`timescale 1ns/1ps

module testbench;
  import usb_status_pkg::*;
  localparam int PERIOD = 40;
  logic        sys_clk, reset, stat_req, stat_vld, stat_last, stat_nak, desc_rd, setup_vld;
  logic        ctl_ack, ctl_stall, ctl_rdata_vld, app_rd, app_wr, reg_wr, reg_rd;
  logic [7:0]  serial_irq_ident_reg, dsr, stat_data, desc_data, ep0_mps, ctl_rdata, app_rdata, reg_addr;
  logic [5:0]  desc_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  fifo_flags_t flags;
  setup_t      setup;
  app_req_t    app_req;
  logic [7:0]  desc_exp [0:44];
  logic [31:0] ep_tab [5];
  logic [71:0] if_desc;
  int          error_cnt, comparisons;

  usb_endpoint_status_reporter #(.REPORT_CYCLES(PERIOD)) usb_endpoint_status_reporter_inst (
    .SYS_CLK(sys_clk), .RESET(reset), .SERIAL_IRQ_IDENT_REG(serial_irq_ident_reg), .PRINTER_STATUS_REG(dsr),
    .PRINTER_IN_FIFO_FULL_FLAG(flags.printer_in_fifo_full_flag),
    .PRINTER_IN_FIFO_EMPTY_FLAG(flags.printer_in_fifo_empty_flag),
    .PRINTER_OUT_FIFO_FULL_FLAG(flags.printer_out_fifo_full_flag),
    .PRINTER_OUT_FIFO_EMPTY_FLAG(flags.printer_out_fifo_empty_flag),
    .SERIAL_OUT_FIFO_EMPTY_FLAG(flags.serial_out_fifo_empty_flag),
    .SERIAL_IN_FIFO_HAS_DATA_FLAG(flags.serial_in_fifo_has_data_flag),
    .STAT_IN_REQ(stat_req), .STAT_DATA(stat_data), .STAT_VLD(stat_vld), .STAT_LAST(stat_last),
    .STAT_NAK(stat_nak), .DESC_RD(desc_rd), .DESC_ADDR(desc_addr), .DESC_DATA(desc_data),
    .EP0_MAX_PKT(ep0_mps), .SETUP_VLD(setup_vld), .SETUP(setup), .CTL_ACK(ctl_ack),
    .CTL_STALL(ctl_stall), .CTL_RDATA(ctl_rdata), .CTL_RDATA_VLD(ctl_rdata_vld), .APP_RD(app_rd),
    .APP_WR(app_wr), .APP_REQ(app_req), .APP_RDATA(app_rdata), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata)
  );

  app_core_model app_core_model_inst (
    .clk(sys_clk), .rd(app_rd), .wr(app_wr), .req(app_req), .rdata(app_rdata)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    reg_addr  <= a;
    reg_wdata <= wd;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_access

  task automatic wait_ready();
    for (int i = 0; i < 60; i++) begin
      reg_access(1'b0, 8'h08, 32'h0000_0000, rd_val);
      if (rd_val[0] === 1'b1) return;
    end
    chk("report_ready", 32'h0000_0001, rd_val);
  endtask : wait_ready

  task automatic poll(input logic take, input logic [7:0] e_iir, e_dsr, input fifo_flags_t f);
    logic [7:0] exp [4];
    exp[0] = e_iir;
    exp[1] = 8'h00;
    exp[2] = e_dsr;
    exp[3] = {2'b00, f.serial_in_fifo_has_data_flag, f.serial_out_fifo_empty_flag,
              f.printer_out_fifo_empty_flag, f.printer_out_fifo_full_flag,
              f.printer_in_fifo_empty_flag, f.printer_in_fifo_full_flag};
    @(posedge sys_clk);
    stat_req <= 1'b1;
    #1;
    chk("stat_nak", 32'(!take), 32'(stat_nak));
    @(posedge sys_clk);
    stat_req <= 1'b0;
    #1;
    for (int i = 0; i < 4 && take; i++) begin
      chk("stat_vld", 32'h0000_0001, 32'(stat_vld));
      chk("stat_data", 32'(exp[i]), 32'(stat_data));
      chk("stat_last", 32'(i == 3), 32'(stat_last));
      @(posedge sys_clk);
      #1;
    end
    chk("stat_vld_end", 32'h0000_0000, 32'(stat_vld));
  endtask : poll

  task automatic vendor(input logic [7:0] rt, rq, input logic [15:0] val, input int kind, input logic [7:0] e_rd);
    @(posedge sys_clk);
    setup_vld <= 1'b1;
    setup     <= '{length: 16'h0001, index: 16'h0003, value: val, request: rq, req_type: rt};
    @(posedge sys_clk);
    setup_vld <= 1'b0;
    #1;
    chk("ctl_stall", 32'(kind == 0), 32'(ctl_stall));
    chk("app_wr", 32'(kind == 1), 32'(app_wr));
    chk("ctl_ack", 32'(kind == 1), 32'(ctl_ack));
    chk("app_rd", 32'(kind == 2), 32'(app_rd));
    if (kind != 0) chk("app_req", {val[15:8], 16'h0003, val[7:0]}, app_req);
    if (kind == 2) begin
      repeat (2) @(posedge sys_clk);
      #1;
      chk("ctl_rdata_vld", 32'h0000_0001, 32'(ctl_rdata_vld));
      chk("ctl_rdata", 32'(e_rd), 32'(ctl_rdata));
    end
  endtask : vendor

  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    reset       = 1'b1;
    stat_req    = 1'b0;
    desc_rd     = 1'b0;
    desc_addr   = 6'h00;
    setup_vld   = 1'b0;
    setup       = '0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0000_0000;
    serial_irq_ident_reg         = 8'hC1;
    dsr         = 8'h78;
    flags       = 6'b10_1010;
    error_cnt   = 0;
    comparisons = 0;
    // Endpoint address, attribute, packet size low byte, interval
    ep_tab[0]   = 32'h8102_20FF;
    ep_tab[1]   = 32'h0202_20FF;
    ep_tab[2]   = 32'h8302_4001;
    ep_tab[3]   = 32'h0402_20FF;
    ep_tab[4]   = 32'h8703_0401;
    if_desc     = 72'h09_0400_0005_FF00_FF00;
    for (int a = 0; a < 9; a++) begin
      desc_exp[a] = if_desc[71 - 8 * a -: 8];
    end
    for (int k = 0; k < 5; k++) begin
      desc_exp[9 + 7 * k]  = 8'h07;
      desc_exp[10 + 7 * k] = 8'h05;
      desc_exp[11 + 7 * k] = ep_tab[k][31:24];
      desc_exp[12 + 7 * k] = ep_tab[k][23:16];
      desc_exp[13 + 7 * k] = ep_tab[k][15:8];
      desc_exp[14 + 7 * k] = 8'h00;
      desc_exp[15 + 7 * k] = ep_tab[k][7:0];
    end
    desc_exp[44] = 8'h00;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("ep0_max_pkt", 32'h0000_0008, 32'(ep0_mps));
    reg_access(1'b0, 8'h00, 32'h0000_0000, rd_val);
    chk("ctrl_reset", 32'h0000_0001, rd_val);
    for (int a = 0; a <= 44; a++) begin
      @(posedge sys_clk);
      desc_rd   <= 1'b1;
      desc_addr <= 6'(a);
      @(posedge sys_clk);
      desc_rd <= 1'b0;
      #1;
      chk("desc_data", 32'(desc_exp[a]), 32'(desc_data));
    end
    wait_ready();
    poll(1'b1, 8'hC1, 8'h78, 6'b10_1010);
    poll(1'b0, 8'hC1, 8'h78, 6'b10_1010);
    reg_access(1'b0, 8'h04, 32'h0000_0000, rd_val);
    chk("report_reg", 32'h2A78_00C1, rd_val);
    serial_irq_ident_reg   <= 8'h3E;
    dsr   <= 8'h87;
    flags <= 6'b01_0101;
    wait_ready();
    poll(1'b1, 8'h3E, 8'h87, 6'b01_0101);
    reg_access(1'b1, 8'h00, 32'h0000_0000, rd_val);
    for (int s = 0; s < 3; s++) begin
      vendor(8'h40, 8'h0E, {8'(s), 8'h5A + 8'(s)}, 1, 8'h00);
      vendor(8'hC0, 8'h0D, {8'(s), 8'h00}, 2, 8'h5A + 8'(s));
    end
    vendor(8'h40, 8'h0E, 16'h0311, 0, 8'h00);
    vendor(8'hC0, 8'h0C, 16'h0100, 0, 8'h00);
    repeat (2 * PERIOD) @(posedge sys_clk);
    poll(1'b0, 8'h3E, 8'h87, 6'b01_0101);
    reg_access(1'b0, 8'h08, 32'h0000_0000, rd_val);
    chk("state_idle", 32'h0000_0000, rd_val);
    reg_access(1'b0, 8'h0C, 32'h0000_0000, rd_val);
    chk("unmapped", 32'h0000_0000, rd_val);
    wrap_up();
  end
endmodule : testbench
